//--- rtl/dlat_pkg.sv
// Package for the low-power and alert timing block of a DDR4 device.
// Assumes a single 125 MHz system clock; all counts are in those cycles.
`default_nettype none
package dlat_pkg;
   localparam int CLK_PERIOD_NS = 8;

   // Command path disable delay after clock enable is registered low.
   localparam logic [2:0] CPDED_CYC = 3'h4;

   // Parity latency and the alert timing around a parity error.
   localparam int PL_CYC = 5;
   localparam int PAR_ALERT_ON_NS = 6;
   localparam int PAR_ALERT_DLY_RAW = PAR_ALERT_ON_NS / CLK_PERIOD_NS;
   localparam int PAR_ALERT_DLY_CYC =
      (PAR_ALERT_DLY_RAW < 1) ? 1 : PAR_ALERT_DLY_RAW;
   localparam int PAR_ALERT_PW_MIN = 80;
   localparam int PAR_ALERT_PW_MAX = 160;
   localparam int PAR_ALERT_PW_CYC = 120;

   // CRC alert latency window in ns and its pulse width in cycles.
   localparam int CRC_ALERT_MIN_NS = 3;
   localparam int CRC_ALERT_MAX_NS = 13;
   localparam int CRC_ALERT_DLY_MIN =
      (CRC_ALERT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CRC_ALERT_DLY_RAW = CRC_ALERT_MAX_NS / CLK_PERIOD_NS;
   localparam int CRC_ALERT_DLY_CYC =
      (CRC_ALERT_DLY_RAW < 1) ? 1 : CRC_ALERT_DLY_RAW;
   localparam int CRC_ALERT_PW_MIN = 6;
   localparam int CRC_ALERT_PW_MAX = 10;
   localparam int CRC_ALERT_PW_CYC = 8;

   // Internal write start offsets after write latency.
   localparam logic [5:0] WR_START_BL8 = 6'h04;
   localparam logic [5:0] WR_START_BC4 = 6'h02;
   localparam int WR_PIPE_W = 40;

   // Time an activate, precharge or refresh keeps the array busy.
   localparam logic [3:0] OP_BUSY_CYC = 4'h8;

   // Register byte offsets.
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_ERRCNT = 4'h8;

   // Control register fields and reset values.
   localparam int CTRL_PAR_EN = 0;
   localparam int CTRL_BC4_MRS = 1;
   localparam int CTRL_WL_LSB = 8;
   localparam logic [4:0] WL_RESET = 5'h09;

   // Status register fields.
   localparam int ST_CKE = 0;
   localparam int ST_PATH_EN = 1;
   localparam int ST_ALERT = 2;
   localparam int ST_BUSY = 3;
   localparam int ST_PAR_SEEN = 4;
   localparam int ST_CRC_SEEN = 5;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [3:0] {
      CMD_DES = 4'h0,
      CMD_ACT = 4'h1,
      CMD_PRE = 4'h2,
      CMD_PREA = 4'h3,
      CMD_REF = 4'h4,
      CMD_RD = 4'h5,
      CMD_RDA = 4'h6,
      CMD_WR = 4'h7,
      CMD_WRA = 4'h8,
      CMD_MRS = 4'h9
   } dlat_cmd_t;
endpackage
`default_nettype wire

//--- rtl/dlat_alert_pulse.sv
// Alert pulse generator: a trigger yields one pulse of fixed width after
// a fixed delay. Assumes the trigger is a one-cycle pulse on clk_sys.
`default_nettype none
module dlat_alert_pulse
   import dlat_pkg::*;
#(
   parameter int DLY = 1,
   parameter int WIDTH = 8,
   parameter int PW_MIN = 6,
   parameter int PW_MAX = 10
)
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic trig,
   output logic active
);
   localparam logic [8:0] LOAD = 9'(WIDTH + DLY - 1);
   localparam logic [8:0] TOP = 9'(WIDTH);
   logic [8:0] cnt;
   logic [8:0] next_cnt;
   logic [8:0] run_len;

   // A trigger inside a running pulse is absorbed into that pulse.
   always_comb
   begin
      next_cnt = cnt;
      if (cnt != 9'h000)
      begin
         next_cnt = cnt - 9'h001;
      end
      else if (trig)
      begin
         next_cnt = LOAD;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         cnt <= 9'h000;
         active <= 1'b0;
      end
      else
      begin
         cnt <= next_cnt;
         active <= (next_cnt != 9'h000) && (next_cnt <= TOP);
      end
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         run_len <= 9'h000;
      end
      else if (active)
      begin
         run_len <= run_len + 9'h001;
      end
      else
      begin
         run_len <= 9'h000;
      end
   end

   property p_pulse_width;
      @(posedge clk_sys) disable iff (!rstn)
      $fell(active) |-> (run_len >= 9'(PW_MIN)) && (run_len <= 9'(PW_MAX));
   endproperty
   a_pulse_width: assert property (p_pulse_width)
      else $error("Alert pulse width out of range.");
endmodule
`default_nettype wire

//--- rtl/dlat_core.sv
// Device-side command timing, power-down path control and alert logic.
// Assumes an AXI4-Lite master on clk_sys and command inputs already
// decoded and synchronous to clk_sys.
//
// Chosen here: the address map and the AXI4-Lite register port.
`default_nettype none
module dlat_core
   import dlat_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic cke,
   input wire logic cmd_valid,
   input wire logic [3:0] cmd_code,
   input wire logic par_err,
   input wire logic crc_err,
   output logic alert_n,
   output logic cmd_path_en,
   output logic cmd_exec,
   output logic [3:0] cmd_exec_code,
   output logic wr_start,
   output logic op_busy
);
   logic cke_q;
   logic [2:0] lo_cnt;
   logic par_en;
   logic bc4_mrs;
   logic [4:0] wl;
   logic par_seen;
   logic crc_seen;
   logic [15:0] par_cnt;
   logic [15:0] crc_cnt;
   logic [3:0] aw_addr;
   logic aw_hold;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic w_hold;
   logic wr_go;
   logic [31:0] ctrl_word;
   logic [31:0] status_word;
   logic par_hit;
   logic crc_hit;
   logic par_alert;
   logic crc_alert;
   logic in_ok;
   logic [2:0] blk_cnt;
   logic stg_v [PL_CYC];
   logic [3:0] stg_c [PL_CYC];
   logic dir_v;
   logic [3:0] dir_c;
   logic exec_wr;
   logic [5:0] wr_dly;
   logic [WR_PIPE_W-1:0] wr_pipe;
   logic [3:0] op_cnt;
   logic [5:0] chk_cnt;

   assign in_ok = cmd_valid && cmd_path_en && (cmd_code != CMD_DES);
   assign par_hit = par_en && par_err;
   assign crc_hit = crc_err;

   // Clock enable is taken as registered on the edge it is sampled.
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         cke_q <= 1'b0;
         lo_cnt <= CPDED_CYC;
      end
      else
      begin
         cke_q <= cke;
         if (cke_q)
         begin
            lo_cnt <= 3'h0;
         end
         else if (lo_cnt != CPDED_CYC)
         begin
            lo_cnt <= lo_cnt + 3'h1;
         end
      end
   end

   assign cmd_path_en = (lo_cnt != CPDED_CYC);

   // Commands wait out the parity latency so an errant one can be caught
   // together with its neighbours before anything reaches the array.
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         blk_cnt <= 3'h0;
      end
      else if (par_hit)
      begin
         blk_cnt <= 3'(PL_CYC);
      end
      else if (blk_cnt != 3'h0)
      begin
         blk_cnt <= blk_cnt - 3'h1;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         stg_v[0] <= 1'b0;
         stg_c[0] <= CMD_DES;
      end
      else
      begin
         stg_v[0] <= par_en && in_ok && !par_hit && (blk_cnt == 3'h0);
         stg_c[0] <= cmd_code;
      end
   end

   genvar gi;
   generate
      for (gi = 1; gi < PL_CYC; gi++)
      begin : g_stage
         always_ff @(posedge clk_sys or negedge rstn)
         begin
            if (!rstn)
            begin
               stg_v[gi] <= 1'b0;
               stg_c[gi] <= CMD_DES;
            end
            else
            begin
               stg_v[gi] <= stg_v[gi-1] && !par_hit;
               stg_c[gi] <= stg_c[gi-1];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         dir_v <= 1'b0;
         dir_c <= CMD_DES;
      end
      else
      begin
         dir_v <= !par_en && in_ok;
         dir_c <= cmd_code;
      end
   end

   assign cmd_exec = par_en ? stg_v[PL_CYC-1] : dir_v;
   assign cmd_exec_code = par_en ? stg_c[PL_CYC-1] : dir_c;
   assign exec_wr = cmd_exec &&
      ((cmd_exec_code == CMD_WR) || (cmd_exec_code == CMD_WRA));
   assign wr_dly = 6'(wl) + (bc4_mrs ? WR_START_BC4 : WR_START_BL8);

   // One-hot delay line lets back-to-back writes each keep their own start.
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         wr_pipe <= '0;
      end
      else
      begin
         wr_pipe <= (wr_pipe >> 1) |
            ({{(WR_PIPE_W-1){1'b0}}, exec_wr} << (wr_dly - 6'h01));
      end
   end

   assign wr_start = wr_pipe[0];

   // Array operations run to their end whatever clock enable does.
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         op_cnt <= 4'h0;
      end
      else if (cmd_exec && (cmd_exec_code inside {CMD_ACT, CMD_PRE, CMD_PREA,
         CMD_REF, CMD_RDA, CMD_WRA}))
      begin
         op_cnt <= OP_BUSY_CYC;
      end
      else if (op_cnt != 4'h0)
      begin
         op_cnt <= op_cnt - 4'h1;
      end
   end

   assign op_busy = (op_cnt != 4'h0);

   dlat_alert_pulse #(
      .DLY(PAR_ALERT_DLY_CYC),
      .WIDTH(PAR_ALERT_PW_CYC),
      .PW_MIN(PAR_ALERT_PW_MIN),
      .PW_MAX(PAR_ALERT_PW_MAX)
   ) u_par_alert (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .trig(par_hit),
      .active(par_alert)
   );

   dlat_alert_pulse #(
      .DLY(CRC_ALERT_DLY_CYC),
      .WIDTH(CRC_ALERT_PW_CYC),
      .PW_MIN(CRC_ALERT_PW_MIN),
      .PW_MAX(CRC_ALERT_PW_MAX)
   ) u_crc_alert (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .trig(crc_hit),
      .active(crc_alert)
   );

   assign alert_n = !(par_alert || crc_alert);

   // Register bus: address and data may arrive in either order.
   assign s_axi_awready = !aw_hold && !s_axi_bvalid;
   assign s_axi_wready = !w_hold && !s_axi_bvalid;
   assign wr_go = aw_hold && w_hold && !s_axi_bvalid;

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         aw_hold <= 1'b0;
         aw_addr <= 4'h0;
         w_hold <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr == REG_CTRL || aw_addr == REG_STATUS ||
               aw_addr == REG_ERRCNT) ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         par_en <= 1'b0;
         bc4_mrs <= 1'b0;
         wl <= WL_RESET;
      end
      else if (wr_go && aw_addr == REG_CTRL)
      begin
         if (w_strb[0])
         begin
            par_en <= w_data[CTRL_PAR_EN];
            bc4_mrs <= w_data[CTRL_BC4_MRS];
         end
         if (w_strb[1])
         begin
            wl <= w_data[CTRL_WL_LSB +: 5];
         end
      end
   end

   // Sticky error flags: a new error in the clearing cycle is kept.
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         par_seen <= 1'b0;
         crc_seen <= 1'b0;
      end
      else
      begin
         par_seen <= par_hit || (par_seen && !(wr_go &&
            aw_addr == REG_STATUS && w_strb[0] && w_data[ST_PAR_SEEN]));
         crc_seen <= crc_hit || (crc_seen && !(wr_go &&
            aw_addr == REG_STATUS && w_strb[0] && w_data[ST_CRC_SEEN]));
      end
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         par_cnt <= 16'h0000;
         crc_cnt <= 16'h0000;
      end
      else
      begin
         par_cnt <= par_cnt + {15'h0000, par_hit};
         crc_cnt <= crc_cnt + {15'h0000, crc_hit};
      end
   end

   assign ctrl_word = {19'h00000, wl, 6'h00, bc4_mrs, par_en};
   assign status_word = {26'h0000000, crc_seen, par_seen, op_busy,
      !alert_n, cmd_path_en, cke_q};
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         case (s_axi_araddr)
            REG_CTRL: s_axi_rdata <= ctrl_word;
            REG_STATUS: s_axi_rdata <= status_word;
            REG_ERRCNT: s_axi_rdata <= {crc_cnt, par_cnt};
            default:
            begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Helper that follows the oldest write so its start can be checked.
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         chk_cnt <= 6'h00;
      end
      else if (chk_cnt != 6'h00)
      begin
         chk_cnt <= chk_cnt - 6'h01;
      end
      else if (exec_wr)
      begin
         chk_cnt <= wr_dly;
      end
   end

   property p_path_off;
      @(posedge clk_sys) disable iff (!rstn)
      $fell(cke_q) |-> cmd_path_en [*4] ##1 (!cmd_path_en || cke_q);
   endproperty
   a_path_off: assert property (p_path_off)
      else $error("Command path not disabled four cycles after cke low.");

   property p_par_flush;
      @(posedge clk_sys) disable iff (!rstn)
      par_hit |-> ##1 (!cmd_exec || !par_en) [*5];
   endproperty
   a_par_flush: assert property (p_par_flush)
      else $error("Command executed inside the parity window.");

   property p_par_latency;
      @(posedge clk_sys) disable iff (!rstn)
      (par_en && cmd_exec) |-> $past(cmd_valid, 5);
   endproperty
   a_par_latency: assert property (p_par_latency)
      else $error("Command executed without parity latency.");

   property p_par_alert_on;
      @(posedge clk_sys) disable iff (!rstn)
      par_hit |-> ##1 !alert_n;
   endproperty
   a_par_alert_on: assert property (p_par_alert_on)
      else $error("Alert late after parity error.");

   property p_crc_alert_on;
      @(posedge clk_sys) disable iff (!rstn)
      crc_hit |-> ##1 !alert_n;
   endproperty
   a_crc_alert_on: assert property (p_crc_alert_on)
      else $error("Alert late after CRC error.");

   property p_wr_start;
      @(posedge clk_sys) disable iff (!rstn)
      (chk_cnt == 6'h01) |-> wr_start;
   endproperty
   a_wr_start: assert property (p_wr_start)
      else $error("Internal write did not start on time.");

   property p_op_finish;
      @(posedge clk_sys) disable iff (!rstn)
      (!cke_q && op_cnt > 4'h1 && !cmd_exec) |=>
         op_cnt == $past(op_cnt) - 4'h1;
   endproperty
   a_op_finish: assert property (p_op_finish)
      else $error("Array operation stalled while cke low.");
endmodule
`default_nettype wire

//--- tb/dlat_ctrl_model.sv
// Controller-side model: drives clock enable and commands to the core.
// Assumes a free-running clk_sys and task calls from one bench process.
`default_nettype none
module dlat_ctrl_model
   import dlat_pkg::*;
#(
   parameter int WL = 9,
   parameter int RL = 11,
   parameter int WR_NS = 15,
   parameter int MOD_CYC = 24
)
(
   input wire logic clk_sys,
   output logic cke,
   output logic cmd_valid,
   output logic [3:0] cmd_code
);
   timeunit 1ns;
   timeprecision 1ps;
   // Nanosecond figures are rounded up to whole cycles.
   localparam int WR_CYC = (WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   int cyc = 0;
   int pd_ok = 0;
   int cke_ok = 0;
   int cmd_ok = 0;
   // Per-device set spacing: 10 ns rounds to two cycles, so 16 wins.
   localparam int PDA_MRD_CYC = 16;
   // Leveling start delay; it also covers the shorter strobe-drive wait.
   localparam int WLMRD_CYC = 40;
   int mrs_ok = 0;
   int wr_ok = 0;
   initial
   begin
      cke = 1'b0;
      cmd_valid = 1'b0;
      cmd_code = 4'h0;
   end
   // The clock never stops and power-down stays short, so the clock
   // windows around entry and exit hold.
   // Power-down always ends well inside its upper bound.
   always @(posedge clk_sys) cyc <= cyc + 1;
   task automatic send(input logic [3:0] c);
      int need;
      // Each command loads the wait before power-down entry.
      // The full-burst figure also covers the fixed chop case, which is
      // shorter, at the cost of a slightly late entry.
      case (c)
         CMD_RD, CMD_RDA: need = RL + 5;
         CMD_WR: need = WL + 4 + WR_CYC;
         CMD_WRA: need = WL + 4 + WR_CYC + 1;
         CMD_MRS: need = MOD_CYC;
         default: need = 2;
      endcase
      while (cyc < cmd_ok || (c == CMD_MRS && cyc < mrs_ok) ||
         ((c == CMD_WR || c == CMD_WRA) && cyc < wr_ok))
         @(posedge clk_sys);
      @(posedge clk_sys);
      cmd_valid <= 1'b1;
      cmd_code <= c;
      @(posedge clk_sys);
      // Between commands the bus carries deselect.
      cmd_valid <= 1'b0;
      if (cyc + need > pd_ok) pd_ok = cyc + need;
      if (c == CMD_MRS)
      begin
         // Spacing for per-device mode register sets.
         mrs_ok = cyc + PDA_MRD_CYC;
         // This set may have switched on write leveling, so the strobe
         // that a write drives waits out the start delays.
         wr_ok = cyc + WLMRD_CYC;
      end
   endtask
   task automatic set_cke(input logic v);
      // Each level is held at least three cycles.
      while (cyc < cke_ok || (!v && cyc < pd_ok)) @(posedge clk_sys);
      @(posedge clk_sys);
      cke <= v;
      cke_ok = cyc + 4;
      // The loop stays locked, so reads, the only commands that need the
      // lock, wait the same exit time as all others.
      if (v) cmd_ok = cyc + 5;
   endtask
endmodule
`default_nettype wire

//--- tb/dlat_core_test.sv
// Bench for the timing core: registers over AXI4-Lite, command execution,
// clock-enable path control and alert pulses.
// Assumes the hand-over latencies of the core and the controller model.
`default_nettype none
module dlat_core_test
   import dlat_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic [3:0] awaddr = 4'h0;
   logic [3:0] araddr = 4'h0;
   logic [3:0] wstrb = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, par_err = 1'b0, crc_err = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rsp;
   logic [31:0] rdata, rd;
   logic cke, cmd_valid, alert_n, cmd_path_en, cmd_exec, wr_start, op_busy;
   logic [3:0] cmd_code, cmd_exec_code;
   logic [4:0] mon;
   int fails = 0, num_checks = 0, n = 0, execs = 0, e = 0;
   assign mon = {cmd_path_en, op_busy, wr_start, cmd_exec, alert_n};
   initial
   begin
      forever #4 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) if (cmd_exec === 1'b1) execs++;
   dlat_core dut (.clk_sys(clk_sys), .rstn(rstn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .cke(cke), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .par_err(par_err), .crc_err(crc_err),
      .alert_n(alert_n), .cmd_path_en(cmd_path_en), .cmd_exec(cmd_exec),
      .cmd_exec_code(cmd_exec_code), .wr_start(wr_start),
      .op_busy(op_busy));
   dlat_ctrl_model ctl (.clk_sys(clk_sys), .cke(cke),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code));
   task automatic close_out();
      if (fails == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Counts edges until a watched output takes a level, up to a limit.
   task automatic wait_bit(input int i, input logic v, input int lim);
      n = 0;
      #1;
      while (mon[i] !== v && n < lim)
      begin
         @(posedge clk_sys);
         #1;
         n++;
      end
   endtask
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
      output logic [1:0] r);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge clk_sys);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= 4'hF;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge clk_sys);
         if (awready === 1'b1) aw_ok = 1'b1;
         if (wready === 1'b1) w_ok = 1'b1;
         if (aw_ok) awvalid <= 1'b0;
         if (w_ok) wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1) @(posedge clk_sys);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
      output logic [1:0] r);
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk_sys); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge clk_sys);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   task automatic pulse(input bit crc);
      @(posedge clk_sys);
      if (crc) crc_err <= 1'b1;
      else par_err <= 1'b1;
      @(posedge clk_sys);
      crc_err <= 1'b0;
      par_err <= 1'b0;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      fails++;
      close_out();
   end
   initial
   begin
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      axi_rd(REG_CTRL, rd, rsp);
      chk("ctrl reset", rd, 32'(WL_RESET) << CTRL_WL_LSB);
      axi_rd(4'hC, rd, rsp);
      chk("unmapped read data", rd, 32'h0);
      chk("unmapped read resp", 32'(rsp), 32'(RESP_SLVERR));
      axi_wr(4'hC, 32'hFFFF_FFFF, rsp);
      chk("unmapped write resp", 32'(rsp), 32'(RESP_SLVERR));
      ctl.set_cke(1'b1);
      wait_bit(4, 1'b1, 20);
      chk("path up after reset", n, 2);
      ctl.send(CMD_DES);
      wait_bit(1, 1'b1, 6);
      chk("deselect ignored", n, 6);
      for (int c = 1; c <= 9; c++)
      begin
         ctl.send(4'(c));
         wait_bit(1, 1'b1, 10);
         chk("exec latency", n, 0);
         chk("exec code", 32'(cmd_exec_code), c);
      end
      wait_bit(3, 1'b0, 40);
      for (int bc = 0; bc <= 1; bc++)
      begin
         axi_wr(REG_CTRL, 32'h0000_0900 | (bc << CTRL_BC4_MRS), rsp);
         ctl.send(CMD_WR);
         wait_bit(1, 1'b1, 10);
         wait_bit(2, 1'b1, 40);
         chk("write start", n, 32'(WL_RESET) +
            32'(bc ? WR_START_BC4 : WR_START_BL8));
      end
      // Clock enable drops while the activate still keeps the array busy.
      ctl.send(CMD_ACT);
      ctl.set_cke(1'b0);
      wait_bit(4, 1'b0, 20);
      chk("path off delay", n, 32'(CPDED_CYC) + 1);
      wait_bit(3, 1'b0, 20);
      chk("busy finishes", 32'(n < 8), 1);
      ctl.send(CMD_RD);
      wait_bit(1, 1'b1, 12);
      chk("refused while off", n, 12);
      ctl.set_cke(1'b1);
      wait_bit(4, 1'b1, 20);
      chk("path on again", n, 2);
      axi_wr(REG_CTRL, 32'h0000_0901, rsp);
      ctl.send(CMD_RD);
      wait_bit(1, 1'b1, 10);
      chk("parity exec latency", n, PL_CYC - 1);
      fork
         ctl.send(CMD_WR);
         pulse(1'b0);
      join
      // Counted here so the read that just executed is already in execs.
      e = execs;
      wait_bit(0, 1'b0, 10);
      chk("parity alert delay", n, 0);
      wait_bit(0, 1'b1, 200);
      chk("parity alert width", n, PAR_ALERT_PW_CYC);
      chk("errant dropped", execs - e, 0);
      pulse(1'b1);
      wait_bit(0, 1'b0, 10);
      chk("crc alert delay", n, 0);
      wait_bit(0, 1'b1, 20);
      chk("crc alert width", n, CRC_ALERT_PW_CYC);
      axi_rd(REG_STATUS, rd, rsp);
      chk("status sticky", rd, 32'h0000_0033);
      axi_wr(REG_ERRCNT, 32'h0, rsp);
      axi_rd(REG_ERRCNT, rd, rsp);
      chk("error counts", rd, 32'h0001_0001);
      axi_wr(REG_STATUS, 32'h0000_0030, rsp);
      axi_rd(REG_STATUS, rd, rsp);
      chk("status cleared", rd, 32'h0000_0003);
      close_out();
   end
endmodule
`default_nettype wire
